/* File: omxbs_top.sv */
// register bank for the shared pin output mux and the band calibration status
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - selected internal signal drives enabled shared pin
// - select zero drives the test data bit
// - codes 1-7: lock detect, slip indicators, reserved
// - codes 8-11: reference, dividers, modulator clock
// - codes 12-17: auxiliary serial, phase detector pulses
// - codes 18-25: modulator clocks, strobes, latch, sync
// - 26-29 unused, 30 buffer enable, 31 reset
// - inhibit bit set gives selected signal only
// - driver always on, else only during read
// - status reports band chosen by calibration
// - manual band override never updates status field
// - band zero is highest frequency, rising downward
// - busy held high while calibration searches
module omxbs_top
    import omxbs_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    // register access port
    input wire logic [5:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic [omxbs_pkg::OMXBS_DATA_W-1:0] REG_WDATA_I,
    output logic [omxbs_pkg::OMXBS_DATA_W-1:0] REG_RDATA_O,
    // serial read cycle from the serial port
    input wire logic RD_ACTIVE_I,
    input wire logic RD_DATA_I,
    // lock detect and slip sources, codes 1 to 7
    input wire logic LOCK_DET_I,
    input wire logic LOCK_TRIG_I,
    input wire logic LOCK_WIN_I,
    input wire logic RING_OSC_I,
    input wire logic SLIP_UP_I,
    input wire logic SLIP_DN_I,
    // clock and divider sources, codes 8 to 11
    input wire logic REF_BUF_I,
    input wire logic REF_DIV_I,
    input wire logic OSC_DIV_I,
    input wire logic MOD_CLK_I,
    // auxiliary and phase detector sources, codes 12 to 17
    input wire logic AUX_CLK_I,
    input wire logic AUX_SCLK_I,
    input wire logic AUX_SEN_I,
    input wire logic AUX_SDO_I,
    input wire logic PHASE_DET_DN_I,
    input wire logic PHASE_DET_UP_I,
    // strobe sources, codes 18 to 25
    input wire logic [7:0] STROBES_I,
    // buffer enable and soft reset, codes 30 and 31
    input wire logic SDO_BUF_EN_I,
    input wire logic SOFT_RESET_LOW_I,
    // calibration engine
    input wire logic CAL_START_I,
    input wire logic CAL_DONE_I,
    input wire logic [omxbs_pkg::OMXBS_BAND_W-1:0] CAL_BAND_I,
    // shared pin and transistor controls
    output logic LOCK_SERIAL_OUT_PIN_O,
    output logic LOCK_SERIAL_OUT_PIN_OE_N_O,
    output logic PULLUP_TRANSISTOR_DIS_O,
    output logic PULLDOWN_TRANSISTOR_DIS_O
);
    import omxbs_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [OMXBS_CFG_USED_W-1:0] cfg_r;
    logic [OMXBS_CFG_USED_W-1:0] cfg_nxt;
    logic cfg_hit;
    logic stat_hit;
    logic [OMXBS_NSRC-1:0] src;
    logic [OMXBS_BAND_W-1:0] band;
    logic busy;
    logic [OMXBS_SEL_W-1:0] sel;
    logic nomux;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    //////////////////////////////////////////////////////////////////////////
    // address decode; status register ignores writes
    assign cfg_hit = (REG_ADDR_I == OMXBS_ADDR_PIN_SEL);
    assign stat_hit = (REG_ADDR_I == OMXBS_ADDR_BAND_STAT);
    assign cfg_nxt = (REG_WR_I && cfg_hit) ? REG_WDATA_I[OMXBS_CFG_USED_W-1:0] : cfg_r;

    // only the implemented low bits are stored, upper bits read zero
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= OMXBS_PIN_SEL_RST[OMXBS_CFG_USED_W-1:0];
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // read data is combinational; unmapped addresses read zero
    assign REG_RDATA_O = cfg_hit ? {{(OMXBS_DATA_W-OMXBS_CFG_USED_W){1'b0}}, cfg_r} :
                         stat_hit ? {{(OMXBS_DATA_W-OMXBS_BAND_W-1){1'b0}}, busy, band} :
                         '0;

    //////////////////////////////////////////////////////////////////////////
    // source vector in select-code order; bit 0 is replaced by test data
    assign src[0] = 1'b0;
    assign src[3:1] = {LOCK_WIN_I, LOCK_TRIG_I, LOCK_DET_I};
    assign src[4] = RING_OSC_I;
    assign src[6:5] = {SLIP_DN_I, SLIP_UP_I};
    assign src[7] = 1'b0;
    assign src[11:8] = {MOD_CLK_I, OSC_DIV_I, REF_DIV_I, REF_BUF_I};
    assign src[15:12] = {AUX_SDO_I, AUX_SEN_I, AUX_SCLK_I, AUX_CLK_I};
    assign src[17:16] = {PHASE_DET_UP_I, PHASE_DET_DN_I};
    assign src[25:18] = STROBES_I;
    assign src[29:26] = 4'h0;
    assign src[31:30] = {SOFT_RESET_LOW_I, SDO_BUF_EN_I};

    omxbs_pin_mux u_mux (
        .clk_i(CLK_I),
        .rst_n_i(rst_n),
        .sel_i(cfg_r[OMXBS_SEL_LSB +: OMXBS_SEL_W]),
        .test_data_i(cfg_r[OMXBS_TEST_BIT]),
        .no_automux_i(cfg_r[OMXBS_NOMUX_BIT]),
        .drv_on_i(cfg_r[OMXBS_DRV_ON_BIT]),
        .src_i(src),
        .rd_active_i(RD_ACTIVE_I),
        .rd_data_i(RD_DATA_I),
        .pin_o(LOCK_SERIAL_OUT_PIN_O),
        .pin_oe_n_o(LOCK_SERIAL_OUT_PIN_OE_N_O)
    );

    omxbs_band_cal u_cal (
        .clk_i(CLK_I),
        .rst_n_i(rst_n),
        .cal_start_i(CAL_START_I),
        .cal_done_i(CAL_DONE_I),
        .cal_band_i(CAL_BAND_I),
        .band_o(band),
        .busy_o(busy)
    );

    // transistor disables pass straight from the register
    assign PULLUP_TRANSISTOR_DIS_O = cfg_r[OMXBS_PULLUP_DIS_BIT];
    assign PULLDOWN_TRANSISTOR_DIS_O = cfg_r[OMXBS_PULLDN_DIS_BIT];

    // select field and inhibit bit, named for the pin checks below
    assign sel = cfg_r[OMXBS_SEL_LSB +: OMXBS_SEL_W];
    assign nomux = cfg_r[OMXBS_NOMUX_BIT];

    property p_cfg_wr;
        @(posedge CLK_I) disable iff (!rst_n)
        (REG_WR_I && cfg_hit) |=> (cfg_r == $past(REG_WDATA_I[OMXBS_CFG_USED_W-1:0]));
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("config write not stored");

    property p_stat_rd;
        @(posedge CLK_I) disable iff (!rst_n)
        stat_hit |-> (REG_RDATA_O[OMXBS_BUSY_BIT] == busy && REG_RDATA_O[OMXBS_BAND_W-1:0] == band &&
                      REG_RDATA_O[OMXBS_DATA_W-1:OMXBS_BUSY_BIT+1] == '0);
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("status read wrong");

    //////////////////////////////////////////////////////////////////////////
    // pin against the named source pins, so a wrong slot in the vector shows up
    property p_code1;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h01) |=> (LOCK_SERIAL_OUT_PIN_O == $past(LOCK_DET_I));
    endproperty
    a_code1: assert property (p_code1) else $error("code 1 does not show lock detect");

    property p_code2;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h02) |=> (LOCK_SERIAL_OUT_PIN_O == $past(LOCK_TRIG_I));
    endproperty
    a_code2: assert property (p_code2) else $error("code 2 does not show lock trigger");

    property p_code3;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h03) |=> (LOCK_SERIAL_OUT_PIN_O == $past(LOCK_WIN_I));
    endproperty
    a_code3: assert property (p_code3) else $error("code 3 does not show lock window");

    property p_code5;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h05) |=> (LOCK_SERIAL_OUT_PIN_O == $past(SLIP_UP_I));
    endproperty
    a_code5: assert property (p_code5) else $error("code 5 does not show slip pull-up");

    property p_code6;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h06) |=> (LOCK_SERIAL_OUT_PIN_O == $past(SLIP_DN_I));
    endproperty
    a_code6: assert property (p_code6) else $error("code 6 does not show slip pull-down");

    property p_code7;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h07) |=> (LOCK_SERIAL_OUT_PIN_O == 1'b0);
    endproperty
    a_code7: assert property (p_code7) else $error("reserved code 7 not low");

    property p_code8;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h08) |=> (LOCK_SERIAL_OUT_PIN_O == $past(REF_BUF_I));
    endproperty
    a_code8: assert property (p_code8) else $error("code 8 does not show reference buffer");

    property p_code9;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h09) |=> (LOCK_SERIAL_OUT_PIN_O == $past(REF_DIV_I));
    endproperty
    a_code9: assert property (p_code9) else $error("code 9 does not show reference divider");

    property p_code10;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h0A) |=> (LOCK_SERIAL_OUT_PIN_O == $past(OSC_DIV_I));
    endproperty
    a_code10: assert property (p_code10) else $error("code 10 does not show oscillator divider");

    property p_code11;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h0B) |=> (LOCK_SERIAL_OUT_PIN_O == $past(MOD_CLK_I));
    endproperty
    a_code11: assert property (p_code11) else $error("code 11 does not show modulator clock");

    property p_code12;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h0C) |=> (LOCK_SERIAL_OUT_PIN_O == $past(AUX_CLK_I));
    endproperty
    a_code12: assert property (p_code12) else $error("code 12 does not show auxiliary clock");

    property p_code13;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h0D) |=> (LOCK_SERIAL_OUT_PIN_O == $past(AUX_SCLK_I));
    endproperty
    a_code13: assert property (p_code13) else $error("code 13 does not show auxiliary serial clock");

    property p_code14;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h0E) |=> (LOCK_SERIAL_OUT_PIN_O == $past(AUX_SEN_I));
    endproperty
    a_code14: assert property (p_code14) else $error("code 14 does not show auxiliary enable");

    property p_code15;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h0F) |=> (LOCK_SERIAL_OUT_PIN_O == $past(AUX_SDO_I));
    endproperty
    a_code15: assert property (p_code15) else $error("code 15 does not show auxiliary data out");

    property p_code16;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h10) |=> (LOCK_SERIAL_OUT_PIN_O == $past(PHASE_DET_DN_I));
    endproperty
    a_code16: assert property (p_code16) else $error("code 16 does not show detector down");

    property p_code17;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h11) |=> (LOCK_SERIAL_OUT_PIN_O == $past(PHASE_DET_UP_I));
    endproperty
    a_code17: assert property (p_code17) else $error("code 17 does not show detector up");

    // strobes run in code order, so the low bits of the offset pick the line
    property p_strobe;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel >= 5'h12 && sel <= 5'h19) |=> (LOCK_SERIAL_OUT_PIN_O == $past(STROBES_I[3'(sel - 5'h12)]));
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe code shows wrong line");

    property p_unused;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel >= 5'h1A && sel <= 5'h1D) |=> (LOCK_SERIAL_OUT_PIN_O == 1'b0);
    endproperty
    a_unused: assert property (p_unused) else $error("unused code not low");

    property p_code30;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h1E) |=> (LOCK_SERIAL_OUT_PIN_O == $past(SDO_BUF_EN_I));
    endproperty
    a_code30: assert property (p_code30) else $error("code 30 does not show buffer enable");

    property p_code31;
        @(posedge CLK_I) disable iff (!rst_n)
        (nomux && sel == 5'h1F) |=> (LOCK_SERIAL_OUT_PIN_O == $past(SOFT_RESET_LOW_I));
    endproperty
    a_code31: assert property (p_code31) else $error("code 31 does not show soft reset");
endmodule

/* File: omxbs_pkg.sv */
// constants for the output mux and band status register bank
package omxbs_pkg;
    // register indices and data width
    localparam logic [5:0] OMXBS_ADDR_PIN_SEL = 6'h0F;
    localparam logic [5:0] OMXBS_ADDR_BAND_STAT = 6'h10;
    localparam int OMXBS_DATA_W = 24;
    // reset values
    localparam logic [23:0] OMXBS_PIN_SEL_RST = 24'h000001;
    localparam logic [7:0] OMXBS_BAND_RST = 8'h20;
    // field positions of the select configuration register
    localparam int OMXBS_SEL_LSB = 0;
    localparam int OMXBS_SEL_W = 5;
    localparam int OMXBS_TEST_BIT = 5;
    localparam int OMXBS_NOMUX_BIT = 6;
    localparam int OMXBS_DRV_ON_BIT = 7;
    localparam int OMXBS_PULLUP_DIS_BIT = 8;
    localparam int OMXBS_PULLDN_DIS_BIT = 9;
    localparam int OMXBS_CFG_USED_W = 10;
    // field positions of the band status register
    localparam int OMXBS_BAND_W = 8;
    localparam int OMXBS_BUSY_BIT = 8;
    // number of internal sources feeding the pin mux
    localparam int OMXBS_NSRC = 32;
    // calibration state machine
    typedef enum logic [1:0] {OMXBS_CAL_IDLE, OMXBS_CAL_SEARCH, OMXBS_CAL_DONE} omxbs_cal_e;
endpackage

/* File: omxbs_pin_mux.sv */
// pin source selection and driver enable for the shared serial out pin
`timescale 1ns/100ps
module omxbs_pin_mux
    import omxbs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // configuration
    input wire logic [OMXBS_SEL_W-1:0] sel_i,
    input wire logic test_data_i,
    input wire logic no_automux_i,
    input wire logic drv_on_i,
    // sources
    input wire logic [OMXBS_NSRC-1:0] src_i,
    input wire logic rd_active_i,
    input wire logic rd_data_i,
    // pin
    output logic pin_o,
    output logic pin_oe_n_o
);
    import omxbs_pkg::*;

    logic [OMXBS_NSRC-1:0] src_all;
    logic sel_bit;
    logic pin_nxt;
    logic pin_r;
    logic oe_n_nxt;
    logic oe_n_r;

    // code zero is the test data bit, others come from the source vector
    assign src_all = {src_i[OMXBS_NSRC-1:1], test_data_i};
    assign sel_bit = src_all[sel_i];
    // automux hands the pin to read data only during a read
    assign pin_nxt = (!no_automux_i && rd_active_i) ? rd_data_i : sel_bit;
    // driver on continuously or only during a read
    assign oe_n_nxt = !(drv_on_i || rd_active_i);

    // registered pin so the data output comes from a flip-flop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            pin_r <= pin_nxt;
            oe_n_r <= oe_n_nxt;
        end
    end

    assign pin_o = pin_r;
    assign pin_oe_n_o = oe_n_r;

    property p_route;
        @(posedge clk_i) disable iff (!rst_n_i)
        (no_automux_i && sel_i != '0) |=> (pin_o == $past(src_i[sel_i]));
    endproperty
    a_route: assert property (p_route) else $error("pin does not follow selected source");

    property p_test;
        @(posedge clk_i) disable iff (!rst_n_i)
        (no_automux_i && sel_i == '0) |=> (pin_o == $past(test_data_i));
    endproperty
    a_test: assert property (p_test) else $error("code zero does not drive test data");

    property p_automux;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!no_automux_i && rd_active_i) |=> (pin_o == $past(rd_data_i));
    endproperty
    a_automux: assert property (p_automux) else $error("read data not muxed onto pin");

    property p_idle_sel;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!no_automux_i && !rd_active_i) |=> (pin_o == $past((sel_i == '0) ? test_data_i : src_i[sel_i]));
    endproperty
    a_idle_sel: assert property (p_idle_sel) else $error("idle pin not showing selected source");

    property p_drv;
        @(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> (pin_oe_n_o == !($past(drv_on_i) || $past(rd_active_i)));
    endproperty
    a_drv: assert property (p_drv) else $error("pin driver enable wrong");
endmodule

/* File: omxbs_band_cal.sv */
// calibration search sequencer that captures the chosen band and busy flag
`timescale 1ns/100ps
module omxbs_band_cal
    import omxbs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // calibration engine
    input wire logic cal_start_i,
    input wire logic cal_done_i,
    input wire logic [OMXBS_BAND_W-1:0] cal_band_i,
    // status
    output logic [OMXBS_BAND_W-1:0] band_o,
    output logic busy_o
);
    import omxbs_pkg::*;

    omxbs_cal_e state_r;
    omxbs_cal_e state_nxt;
    logic [OMXBS_BAND_W-1:0] band_r;
    logic [OMXBS_BAND_W-1:0] band_nxt;

    // busy while searching; result taken only from the engine, never manual writes
    always_comb begin
        state_nxt = state_r;
        band_nxt = band_r;
        case (state_r)
            OMXBS_CAL_IDLE, OMXBS_CAL_DONE: begin
                if (cal_start_i) begin
                    state_nxt = OMXBS_CAL_SEARCH;
                end
            end
            OMXBS_CAL_SEARCH: begin
                if (cal_done_i) begin
                    state_nxt = OMXBS_CAL_DONE;
                    band_nxt = cal_band_i;
                end
            end
            default: begin
                state_nxt = OMXBS_CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= OMXBS_CAL_IDLE;
            band_r <= OMXBS_BAND_RST;
        end else begin
            state_r <= state_nxt;
            band_r <= band_nxt;
        end
    end

    assign band_o = band_r;
    assign busy_o = (state_r == OMXBS_CAL_SEARCH);

    property p_busy;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!busy_o && cal_start_i) |=> busy_o;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not raised on calibration start");

    property p_done;
        @(posedge clk_i) disable iff (!rst_n_i)
        (busy_o && cal_done_i) |=> (!busy_o && band_o == $past(cal_band_i));
    endproperty
    a_done: assert property (p_done) else $error("band not captured at calibration end");

    property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!(busy_o && cal_done_i)) |=> $stable(band_o);
    endproperty
    a_hold: assert property (p_hold) else $error("band changed outside calibration result");
endmodule

/* File: omxbs_spi_host.sv */
// serial port host model that drives read cycles and reads back the band status
`timescale 1ns/100ps
module omxbs_spi_host
    import omxbs_pkg::*;
#(
    parameter logic [7:0] BAND_MASK = 8'hFF
)(
    // clock
    input wire logic clk_i,
    // read cycle control from the bench, status word from the device
    input wire logic rd_req_i,
    input wire logic rd_bit_i,
    input wire logic [23:0] status_i,
    // towards the device, and the band read back towards the bench
    output logic rd_active_o,
    output logic rd_data_o,
    output logic [7:0] band_o
);
    logic idle_pat_r = 1'b0;
    // a released data line toggles so a stale bit never passes for a match
    always_ff @(posedge clk_i) begin
        idle_pat_r <= ~idle_pat_r;
        rd_active_o <= rd_req_i;
        rd_data_o <= rd_req_i ? rd_bit_i : idle_pat_r;
        if (!status_i[OMXBS_BUSY_BIT]) begin
            band_o <= status_i[7:0] & BAND_MASK;
        end
    end
endmodule

/* File: output_mux_and_band_status_tb.sv */
// self-checking bench for the output mux and band status register bank
`timescale 1ns/100ps
module output_mux_and_band_status_tb;
    import omxbs_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] addr = 6'h0F;
    logic wr = 1'b0;
    logic [23:0] wdata = 24'h000000;
    logic [31:0] src = 32'h00000000;
    logic rd_req = 1'b0;
    logic rd_bit = 1'b0;
    logic cal_start = 1'b0;
    logic cal_done = 1'b0;
    logic [7:0] cal_band = 8'h00;
    logic [23:0] rdata;
    logic pin, pin_oe_n, pu_dis, pd_dis, rd_active, rd_data;
    logic [7:0] host_band;
    int fails = 0;
    int checked = 0;
    //////////////////////////////////////////////////////////////////////////////
    // clock, device and host model
    initial begin
        forever #12.5 clk = ~clk;
    end
    omxbs_top dut (.CLK_I(clk), .ARST_N_I(arst_n), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata),
        .REG_RDATA_O(rdata), .RD_ACTIVE_I(rd_active), .RD_DATA_I(rd_data), .LOCK_DET_I(src[1]),
        .LOCK_TRIG_I(src[2]), .LOCK_WIN_I(src[3]), .RING_OSC_I(src[4]), .SLIP_UP_I(src[5]), .SLIP_DN_I(src[6]),
        .REF_BUF_I(src[8]), .REF_DIV_I(src[9]), .OSC_DIV_I(src[10]), .MOD_CLK_I(src[11]), .AUX_CLK_I(src[12]),
        .AUX_SCLK_I(src[13]), .AUX_SEN_I(src[14]), .AUX_SDO_I(src[15]), .PHASE_DET_DN_I(src[16]),
        .PHASE_DET_UP_I(src[17]), .STROBES_I(src[25:18]), .SDO_BUF_EN_I(src[30]), .SOFT_RESET_LOW_I(src[31]),
        .CAL_START_I(cal_start), .CAL_DONE_I(cal_done), .CAL_BAND_I(cal_band), .LOCK_SERIAL_OUT_PIN_O(pin),
        .LOCK_SERIAL_OUT_PIN_OE_N_O(pin_oe_n), .PULLUP_TRANSISTOR_DIS_O(pu_dis), .PULLDOWN_TRANSISTOR_DIS_O(pd_dis));
    omxbs_spi_host host (.clk_i(clk), .rd_req_i(rd_req), .rd_bit_i(rd_bit), .status_i(rdata),
        .rd_active_o(rd_active), .rd_data_o(rd_data), .band_o(host_band));
    //////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one write strobe, address held afterwards so reads stay valid
    task automatic wr_reg(input logic [5:0] a, input logic [23:0] d);
        @(posedge clk);
        addr <= a;
        wr <= 1'b1;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // ends on a rising edge so the caller drives its next inputs there
    task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
        @(posedge clk);
        addr <= a;
        @(negedge clk);
        chk(rdata, exp);
        @(posedge clk);
    endtask
    // pin and driver enable settle two edges after their cause; three for margin
    task automatic pin_chk(input logic p, input logic oe_n);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({22'h0, pin_oe_n, pin}, {22'h0, oe_n, p});
        @(posedge clk);
    endtask
    //////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        @(negedge clk);
        chk({20'h0, pu_dis, pd_dis, pin_oe_n, pin}, 24'h000002);
        chk(rdata, OMXBS_PIN_SEL_RST);
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(OMXBS_ADDR_BAND_STAT, 24'h000020);
        $display("test reset done");
    endtask
    task automatic t_regs();
        wr_reg(OMXBS_ADDR_PIN_SEL, 24'hFFFFFF);
        rd_chk(OMXBS_ADDR_PIN_SEL, 24'h0003FF);
        chk({22'h0, pu_dis, pd_dis}, 24'h000003);
        rd_chk(6'h3F, 24'h000000);
        wr_reg(OMXBS_ADDR_PIN_SEL, 24'h000000);
        rd_chk(OMXBS_ADDR_PIN_SEL, 24'h000000);
        chk({22'h0, pu_dis, pd_dis}, 24'h000000);
        $display("test registers done");
    endtask
    // every select code, with the chosen source opposite to all others
    task automatic t_mux();
        logic v;
        logic e;
        for (int c = 0; c < 32; c++) begin
            for (int k = 0; k < 2; k++) begin
                v = k[0];
                e = (c == 7 || (c >= 26 && c <= 29)) ? 1'b0 : v;
                src <= v ? (32'h1 << c) : ~(32'h1 << c);
                wr_reg(OMXBS_ADDR_PIN_SEL, {16'h0, 2'b11, v, c[4:0]});
                pin_chk(e, 1'b0);
            end
        end
        $display("test mux done");
    endtask
    task automatic t_automux();
        src <= 32'h00000002;
        wr_reg(OMXBS_ADDR_PIN_SEL, 24'h000001);
        pin_chk(1'b1, 1'b1);
        rd_req <= 1'b1;
        rd_bit <= 1'b0;
        pin_chk(1'b0, 1'b0);
        src <= 32'h00000000;
        rd_bit <= 1'b1;
        pin_chk(1'b1, 1'b0);
        src <= 32'h00000002;
        rd_bit <= 1'b0;
        wr_reg(OMXBS_ADDR_PIN_SEL, 24'h000041);
        pin_chk(1'b1, 1'b0);
        rd_req <= 1'b0;
        pin_chk(1'b1, 1'b1);
        wr_reg(OMXBS_ADDR_PIN_SEL, 24'h0000C1);
        pin_chk(1'b1, 1'b0);
        $display("test automux done");
    endtask
    task automatic t_cal();
        int i;
        addr <= OMXBS_ADDR_BAND_STAT;
        cal_done <= 1'b1;
        cal_band <= 8'h55;
        @(posedge clk);
        cal_done <= 1'b0;
        rd_chk(OMXBS_ADDR_BAND_STAT, 24'h000020);
        cal_start <= 1'b1;
        @(posedge clk);
        cal_start <= 1'b0;
        for (i = 0; i < 4 && rdata[8] !== 1'b1; i++) @(negedge clk);
        if (i == 4) begin
            fails++;
            summarize();
        end
        @(posedge clk);
        cal_start <= 1'b1;
        @(posedge clk);
        cal_start <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(rdata, 24'h000120);
        @(posedge clk);
        cal_done <= 1'b1;
        cal_band <= 8'h00;
        @(posedge clk);
        cal_done <= 1'b0;
        @(negedge clk);
        chk(rdata, 24'h000000);
        repeat (2) @(negedge clk);
        chk({16'h0, host_band}, 24'h000000);
        @(posedge clk);
        cal_start <= 1'b1;
        @(posedge clk);
        cal_start <= 1'b0;
        cal_done <= 1'b1;
        cal_band <= 8'hFF;
        @(posedge clk);
        cal_done <= 1'b0;
        @(negedge clk);
        chk(rdata, 24'h0000FF);
        wr_reg(OMXBS_ADDR_BAND_STAT, 24'h0000AA);
        rd_chk(OMXBS_ADDR_BAND_STAT, 24'h0000FF);
        $display("test calibration done");
    endtask
    //////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        t_reset();
        t_regs();
        t_mux();
        t_automux();
        t_cal();
        summarize();
    end
endmodule
